/* src/handler_pkg.sv */
// shared constants, codes and carrier types of the parts-handler handshake block
package handler_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] INT_MASK_OFFSET = 8'h0C;

  // ==========================================================
  // control register fields
  localparam int CTRL_COMP_ON_BIT = 0;
  localparam int CTRL_CONTACT_ON_BIT = 1;
  localparam int CTRL_TRIG_EXT_BIT = 2;
  localparam int CTRL_SOFT_FIRE_BIT = 3;
  localparam int CTRL_CLEAR_HALT_BIT = 4;
  localparam logic [2:0] CTRL_RESET = 3'h3;

  // ==========================================================
  // interrupt status / mask fields
  localparam int INT_WIDTH = 5;
  localparam int INT_RESULT_BIT = 0;
  localparam int INT_ANALOG_BIT = 1;
  localparam int INT_ALARM_BIT = 2;
  localparam int INT_IGNORED_BIT = 3;
  localparam int INT_CONTACT_BIT = 4;
  localparam logic [INT_WIDTH-1:0] INT_STATUS_RESET = 5'h00;
  localparam logic [INT_WIDTH-1:0] INT_MASK_RESET = 5'h00;

  // ==========================================================
  // comparator verdict codes
  localparam logic [1:0] VERDICT_NONE = 2'h0;
  localparam logic [1:0] VERDICT_HIGH = 2'h1;
  localparam logic [1:0] VERDICT_IN = 2'h2;
  localparam logic [1:0] VERDICT_LOW = 2'h3;

  // ==========================================================
  // bus answers and pin levels
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic PIN_IDLE = 1'b1;

  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic [1:0] pri;
    logic [1:0] sec;
    logic contact_fail;
  } verdict_t;

  typedef struct packed {
    logic trig_ext;
    logic contact_on;
    logic comp_on;
  } ctrl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_COMPUTE, ST_PRESENT} meas_state_t;
endpackage

/* src/rise_detect.sv */
// rising edge detector for a synchronous pin input
`timescale 1ns/1ps
`default_nettype none
module rise_detect
  import handler_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic level_in,
  output logic rise
);
  // ==========================================================
  // edge capture
  logic prev;

  // idle level at reset so a pin parked high gives no false edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev <= PIN_IDLE;
    end else if (ce) begin
      prev <= level_in;
    end
  end

  // combinational pulse, one enabled cycle per low-to-high change
  assign rise = level_in & ~prev;
endmodule
`default_nettype wire

/* src/handler_handshake.sv */
// parts-handler handshake controller with AXI4-Lite register slave
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module handler_handshake
  import handler_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic meas_start,
  input wire logic analog_done_in,
  input wire logic result_done_in,
  input wire verdict_t verdict_in,
  input wire logic power_fail,
  input wire logic err_event,
  input wire logic key_valid,
  input wire logic [7:0] key_code,
  output logic key_out_valid,
  output logic [7:0] key_out_code,
  input wire logic remote_fire_n,
  input wire logic key_lock_n,
  output logic pri_above_n,
  output logic pri_pass_n,
  output logic pri_below_n,
  output logic sec_above_n,
  output logic sec_pass_n,
  output logic sec_below_n,
  output logic contact_fail_n,
  output logic alarm_n,
  output logic acq_done_n,
  output logic result_valid_n,
  output logic irq
);
  // ==========================================================
  // helpers
  // verdict code to active-low {high, pass, low}; never more than one low
  function automatic logic [2:0] verdict_lines_n(input logic [1:0] v);
    logic [2:0] lines;
    lines = 3'h7;
    if (v == VERDICT_HIGH) begin
      lines = 3'h3;
    end else if (v == VERDICT_IN) begin
      lines = 3'h5;
    end else if (v == VERDICT_LOW) begin
      lines = 3'h6;
    end
    return lines;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == CTRL_OFFSET) begin
      hit = 1'b1;
    end else if (a == STATUS_OFFSET) begin
      hit = 1'b1;
    end else if (a == INT_STATUS_OFFSET) begin
      hit = 1'b1;
    end else if (a == INT_MASK_OFFSET) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ==========================================================
  // state
  ctrl_t ctrl;
  meas_state_t state, next_state;
  verdict_t last_verdict;
  logic halted, next_halted;
  logic [INT_WIDTH-1:0] int_status, int_mask, next_int_status, events;
  logic [2:0] pri_n, sec_n, next_pri_n, next_sec_n;
  logic nc_n, acq_n, eom_n, next_nc_n, next_acq_n, next_eom_n, next_start;
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ==========================================================
  // trigger edge
  logic fire_rise;

  rise_detect fire_edge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .level_in(remote_fire_n),
    .rise(fire_rise)
  );

  // ==========================================================
  // register bus decode
  wire wr_fire = aw_full & w_full & ~s_axi_bvalid;
  wire wr_lane0 = wr_fire & w_strb[0];
  wire wr_ctrl = wr_lane0 & (aw_addr == CTRL_OFFSET);
  wire wr_int_status = wr_lane0 & (aw_addr == INT_STATUS_OFFSET);
  wire wr_int_mask = wr_lane0 & (aw_addr == INT_MASK_OFFSET);
  wire soft_fire = wr_ctrl & w_data[CTRL_SOFT_FIRE_BIT];
  wire clear_halt = wr_ctrl & w_data[CTRL_CLEAR_HALT_BIT];
  wire [INT_WIDTH-1:0] w1c = wr_int_status ? w_data[INT_WIDTH-1:0] : '0;
  wire [INT_WIDTH-1:0] next_int_mask = wr_int_mask ? w_data[INT_WIDTH-1:0] : int_mask;
  wire ar_take = s_axi_arvalid & s_axi_arready;

  // ==========================================================
  // sequencing decode
  // an error in the same cycle wins over any progress, so nothing moves
  wire go = ~halted & ~err_event;
  wire fire_req = ctrl.trig_ext ? fire_rise : soft_fire;
  wire start = go & (state == ST_IDLE) & fire_req;
  wire acq_end = go & (state == ST_ACQUIRE) & analog_done_in;
  wire res_take = go & (state == ST_COMPUTE) & result_done_in;
  wire nc_on = ctrl.comp_on & ctrl.contact_on;

  // ==========================================================
  // measurement sequence and pin values
  always_comb begin
    next_state = state;
    next_pri_n = pri_n;
    next_sec_n = sec_n;
    next_nc_n = nc_n;
    next_acq_n = acq_n;
    next_eom_n = eom_n;
    next_start = 1'b0;
    if (go) begin
      case (state)
        ST_IDLE: begin
          if (fire_req) begin
            next_state = ST_ACQUIRE;
            next_acq_n = 1'b1;
            next_eom_n = 1'b1;
            next_start = 1'b1;
          end
        end
        ST_ACQUIRE: begin
          if (analog_done_in) begin
            next_state = ST_COMPUTE;
            next_acq_n = 1'b0;
          end
        end
        ST_COMPUTE: begin
          // contact failure is reported, not treated as abort
          if (result_done_in) begin
            next_state = ST_PRESENT;
            next_pri_n = verdict_lines_n(verdict_in.pri);
            next_sec_n = verdict_lines_n(verdict_in.sec);
            next_nc_n = ~verdict_in.contact_fail;
          end
        end
        default: begin
          // result lines settled one cycle earlier
          next_state = ST_IDLE;
          next_eom_n = 1'b0;
        end
      endcase
      if (!ctrl.comp_on) begin
        next_pri_n = 3'h7;
        next_sec_n = 3'h7;
        next_acq_n = 1'b1;
        next_eom_n = 1'b1;
      end
      if (!nc_on) begin
        next_nc_n = 1'b1;
      end
    end
  end

  // halt is set by an error and cleared by software; the set wins
  assign next_halted = err_event | (halted & ~clear_halt);

  // ==========================================================
  // interrupt events
  assign events[INT_RESULT_BIT] = go & (state == ST_PRESENT);
  assign events[INT_ANALOG_BIT] = acq_end;
  assign events[INT_ALARM_BIT] = err_event | power_fail;
  assign events[INT_IGNORED_BIT] = fire_req & ~start;
  assign events[INT_CONTACT_BIT] = res_take & verdict_in.contact_fail;
  assign next_int_status = (int_status & ~w1c) | events;

  // ==========================================================
  // measurement state registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      halted <= 1'b0;
      last_verdict <= '0;
      meas_start <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      halted <= next_halted;
      meas_start <= next_start;
      if (res_take) begin
        last_verdict <= verdict_in;
      end
    end
  end

  // handler pins, all idle high after reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pri_n <= 3'h7;
      sec_n <= 3'h7;
      nc_n <= PIN_IDLE;
      acq_n <= PIN_IDLE;
      eom_n <= PIN_IDLE;
      alarm_n <= PIN_IDLE;
    end else if (ce) begin
      pri_n <= next_pri_n;
      sec_n <= next_sec_n;
      nc_n <= next_nc_n;
      acq_n <= next_acq_n;
      eom_n <= next_eom_n;
      alarm_n <= ~(power_fail | next_halted);
    end
  end

  assign pri_above_n = pri_n[2];
  assign pri_pass_n = pri_n[1];
  assign pri_below_n = pri_n[0];
  assign sec_above_n = sec_n[2];
  assign sec_pass_n = sec_n[1];
  assign sec_below_n = sec_n[0];
  assign contact_fail_n = nc_n;
  assign acq_done_n = acq_n;
  assign result_valid_n = eom_n;

  // keypad pass-through; lockout pin is active low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      key_out_valid <= 1'b0;
      key_out_code <= 8'h00;
    end else if (ce) begin
      key_out_valid <= key_valid & key_lock_n;
      if (key_valid) begin
        key_out_code <= key_code;
      end
    end
  end

  // ==========================================================
  // control and interrupt registers
  // irq built from next values so it tracks status and mask without lag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      int_status <= INT_STATUS_RESET;
      int_mask <= INT_MASK_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl.comp_on <= w_data[CTRL_COMP_ON_BIT];
        ctrl.contact_on <= w_data[CTRL_CONTACT_ON_BIT];
        ctrl.trig_ext <= w_data[CTRL_TRIG_EXT_BIT];
      end
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      irq <= |(next_int_status & next_int_mask);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel: address and data taken in either order
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // unmapped writes change nothing and answer SLVERR
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (s_axi_araddr == CTRL_OFFSET) begin
      rd_mux = {29'h0, ctrl};
    end else if (s_axi_araddr == STATUS_OFFSET) begin
      rd_mux = {19'h0, last_verdict, 3'h0, power_fail, ~key_lock_n, halted, state};
    end else if (s_axi_araddr == INT_STATUS_OFFSET) begin
      rd_mux = {27'h0, int_status};
    end else if (s_axi_araddr == INT_MASK_OFFSET) begin
      rd_mux = {27'h0, int_mask};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // assertions
  property p_pri_onehot;
    @(posedge clk_sys) disable iff (!rstn)
    $onehot0(~{pri_above_n, pri_pass_n, pri_below_n}) && $onehot0(~sec_n);
  endproperty
  a_pri_onehot: assert property (p_pri_onehot) else $error("two verdict lines low");

  property p_remote_fire_n;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && ctrl.trig_ext && fire_rise && !halted && !err_event && state == ST_IDLE)
      |=> meas_start;
  endproperty
  a_remote_fire_n: assert property (p_remote_fire_n) else $error("trigger edge did not start");

  property p_halt_ignore;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && halted && fire_rise) |=> !meas_start;
  endproperty
  a_halt_ignore: assert property (p_halt_ignore) else $error("start while halted");

  property p_halt_freeze;
    @(posedge clk_sys) disable iff (!rstn)
    (halted || err_event) |=> $stable({pri_n, sec_n, nc_n, acq_n, eom_n});
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("pins moved while halted");

  property p_alarm;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && (power_fail || err_event)) |=> !alarm_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not asserted");

  property p_eom_after_results;
    @(posedge clk_sys) disable iff (!rstn)
    $fell(result_valid_n) |-> $stable({pri_n, sec_n, nc_n}) && !acq_done_n;
  endproperty
  a_eom_after_results: assert property (p_eom_after_results) else $error("result-valid early");

  property p_start_release;
    @(posedge clk_sys) disable iff (!rstn)
    meas_start |-> acq_done_n && result_valid_n;
  endproperty
  a_start_release: assert property (p_start_release) else $error("handshake not released");

  property p_comp_off;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && go && !ctrl.comp_on) |=> (&pri_n) && (&sec_n) && acq_done_n && result_valid_n;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("pins driven with comparator off");

  property p_key_lock;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && !key_lock_n) |=> !key_out_valid;
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("key passed under lockout");

  property p_index;
    @(posedge clk_sys) disable iff (!rstn)
    (ce && acq_end && ctrl.comp_on) |=> !acq_done_n ##1 result_valid_n;
  endproperty
  a_index: assert property (p_index) else $error("analog-done missing");

  property p_irq;
    @(posedge clk_sys) disable iff (!rstn)
    irq == |(int_status & int_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq disagrees with status");
endmodule
`default_nettype wire

/* verification/meas_core_model.sv */
// measurement core and parts-handler model facing the handshake block
`timescale 1ns/1ps
`default_nettype none
module meas_core_model
  import handler_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slow,
  input wire logic meas_start,
  input wire logic result_valid_n,
  input wire logic [6:0] pins,
  output logic analog_done_in,
  output logic result_done_in,
  output logic [7:0] starts,
  output logic [7:0] dones,
  output logic [6:0] seen
);
  // ==========================================================
  // core phases
  logic [1:0] ph;
  logic [2:0] cnt;
  logic rv_q;
  logic [2:0] dly;
  assign dly = slow ? 3'h5 : 3'h0;

  // acquisition then computation; slow mode stretches both phases
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      cnt <= 3'h0;
      rv_q <= 1'b1;
      analog_done_in <= 1'b0;
      result_done_in <= 1'b0;
      starts <= 8'h00;
      dones <= 8'h00;
      seen <= 7'h7F;
    end else begin
      analog_done_in <= 1'b0;
      result_done_in <= 1'b0;
      rv_q <= result_valid_n;
      if (meas_start) begin
        ph <= 2'h1;
        cnt <= dly;
        starts <= starts + 8'h01;
      end else if (ph != 2'h0 && cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else if (ph == 2'h1) begin
        analog_done_in <= 1'b1;
        ph <= 2'h2;
        cnt <= dly;
      end else if (ph == 2'h2) begin
        result_done_in <= 1'b1;
        ph <= 2'h0;
        dones <= dones + 8'h01;
      end
      // results taken only on the falling result-valid edge, not on analog done
      if (rv_q && !result_valid_n) begin
        seen <= pins;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the parts-handler handshake block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import handler_pkg::*;
;
  logic clk_sys, rstn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, key_code, key_out_code, starts, dones, ctrl, d0;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, fresh;
  logic meas_start, analog_done_in, result_done_in, power_fail, err_event, key_valid;
  logic key_out_valid, remote_fire_n, key_lock_n, pri_above_n, pri_pass_n, pri_below_n;
  logic sec_above_n, sec_pass_n, sec_below_n, contact_fail_n, alarm_n, acq_done_n;
  logic result_valid_n, irq, slow;
  logic [6:0] pins, seen, p0;
  verdict_t verdict_in;
  int fails, check_count;
  assign pins = {pri_above_n, pri_pass_n, pri_below_n, sec_above_n, sec_pass_n, sec_below_n,
                 contact_fail_n};

  handler_handshake dut_u (.*);
  meas_core_model model_u (.*);

  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // reporting
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    check_count++;
    if (sv !== ev) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask

  task automatic stall();
    fails++;
    conclude();
  endtask

  // expected pin levels, low means asserted
  function automatic logic [6:0] ex(input logic [1:0] p, input logic [1:0] s, input logic c);
    if (!ctrl[0]) return 7'h7F;
    return ~{p == 2'h1, p == 2'h2, p == 2'h3, s == 2'h1, s == 2'h2, s == 2'h3, c & ctrl[1]};
  endfunction

  // ==========================================================
  // bus tasks: valids held until taken, ready held until the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) stall();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) stall();
  endtask

  // one measurement: fire, note the fresh handshake levels, wait for results
  task automatic meas(input logic ext);
    int n;
    n = 0;
    d0 = starts;
    if (ext) begin
      @(posedge clk_sys);
      remote_fire_n <= 1'b0;
      @(posedge clk_sys);
      remote_fire_n <= 1'b1;
    end else begin
      // mode first: the fire bit is decoded against the mode already held
      axw(CTRL_OFFSET, {24'h0, ctrl}, rs);
      axw(CTRL_OFFSET, {24'h0, ctrl | 8'h08}, rs);
    end
    while (starts === d0 && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
    fresh = {acq_done_n, result_valid_n};
    d0 = dones;
    while (dones === d0 && n < 80) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 80) stall();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {power_fail, err_event, key_valid, slow} = 4'h0;
    {ce, remote_fire_n, key_lock_n} = 3'h7;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    key_code = 8'h00;
    verdict_in = '0;
    ctrl = 8'h03;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    #1 chk({pins, alarm_n, irq}, 9'h1FE);
    axr(CTRL_OFFSET, rd, rs);
    chk(rd, {29'h0, CTRL_RESET});
    axr(INT_MASK_OFFSET, rd, rs);
    chk(rd, 32'h0);
    axr(8'h10, rd, rs);
    chk(rs, RESP_SLVERR);
    axw(8'h10, 32'h1F, rs);
    chk(rs, RESP_SLVERR);
    $display("test registers done");
    for (int v = 0; v < 4; v++) begin
      @(posedge clk_sys);
      verdict_in <= '{pri: v[1:0], sec: 2'(3 - v), contact_fail: v[0]};
      meas(1'b0);
      chk(pins, ex(v[1:0], 2'(3 - v), v[0]));
      chk(seen, pins);
      chk({acq_done_n, result_valid_n}, 2'b00);
    end
    $display("test verdicts done");
    ctrl = 8'h07;
    slow <= 1'b1;
    axw(CTRL_OFFSET, 32'h07, rs);
    verdict_in <= '{pri: 2'h1, sec: 2'h2, contact_fail: 1'b0};
    meas(1'b1);
    chk(fresh, 2'b11);
    chk(pins, ex(2'h1, 2'h2, 1'b0));
    slow <= 1'b0;
    $display("test remote trigger done");
    axw(INT_STATUS_OFFSET, 32'h1F, rs);
    axw(INT_MASK_OFFSET, 32'h01, rs);
    #1 chk(irq, 1'b0);
    meas(1'b1);
    chk(irq, 1'b1);
    axw(INT_STATUS_OFFSET, 32'h01, rs);
    #1 chk(irq, 1'b0);
    axw(INT_MASK_OFFSET, 32'h00, rs);
    $display("test interrupt done");
    ctrl = 8'h00;
    meas(1'b0);
    chk({pins, acq_done_n, result_valid_n}, 9'h1FF);
    ctrl = 8'h01;
    @(posedge clk_sys);
    verdict_in <= '{pri: 2'h2, sec: 2'h2, contact_fail: 1'b1};
    meas(1'b0);
    chk(pins, ex(2'h2, 2'h2, 1'b1));
    $display("test comparator off done");
    @(posedge clk_sys);
    key_lock_n <= 1'b0;
    key_code <= 8'h5A;
    key_valid <= 1'b1;
    @(posedge clk_sys);
    key_valid <= 1'b0;
    #1 chk(key_out_valid, 1'b0);
    @(posedge clk_sys);
    key_lock_n <= 1'b1;
    key_valid <= 1'b1;
    @(posedge clk_sys);
    key_valid <= 1'b0;
    #1 chk({key_out_valid, key_out_code}, 9'h15A);
    // enable low: the alarm flop must keep its idle level
    @(posedge clk_sys);
    ce <= 1'b0;
    power_fail <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(alarm_n, 1'b1);
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    power_fail <= 1'b0;
    #1 chk(alarm_n, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk(alarm_n, 1'b1);
    $display("test keys and power done");
    ctrl = 8'h07;
    axw(CTRL_OFFSET, 32'h07, rs);
    verdict_in <= '{pri: 2'h3, sec: 2'h1, contact_fail: 1'b1};
    meas(1'b1);
    p0 = pins;
    d0 = starts;
    @(posedge clk_sys);
    err_event <= 1'b1;
    @(posedge clk_sys);
    err_event <= 1'b0;
    @(posedge clk_sys);
    remote_fire_n <= 1'b0;
    #1 chk(alarm_n, 1'b0);
    @(posedge clk_sys);
    remote_fire_n <= 1'b1;
    // comparator off while halted must not move the frozen lines
    axw(CTRL_OFFSET, 32'h06, rs);
    repeat (6) @(posedge clk_sys);
    #1 chk(starts, d0);
    chk({pins, result_valid_n}, {p0, 1'b0});
    axr(STATUS_OFFSET, rd, rs);
    chk(rd, 32'h00001B04);
    axr(INT_STATUS_OFFSET, rd, rs);
    chk(rd, 32'h0000001F);
    axw(CTRL_OFFSET, 32'h17, rs);
    repeat (2) @(posedge clk_sys);
    #1 chk(alarm_n, 1'b1);
    @(posedge clk_sys);
    verdict_in <= '{pri: 2'h2, sec: 2'h3, contact_fail: 1'b0};
    meas(1'b1);
    chk(pins, ex(2'h2, 2'h3, 1'b0));
    $display("test error halt done");
    conclude();
  end
endmodule
`default_nettype wire
